// ===== hdl/aivp_defs.vh
`ifndef AIVP_DEFS_VH
`define AIVP_DEFS_VH

// apb register byte offsets
`define OFF_CTRL 12'h000
`define OFF_SCALE 12'h004
`define OFF_LIMITS 12'h008
`define OFF_THRESH 12'h00C
`define OFF_SUBST 12'h010
`define OFF_SIMUL 12'h014
`define OFF_FILTER 12'h018
`define OFF_STATUS 12'h01C
`define OFF_IRQ_STAT 12'h020
`define OFF_IRQ_MASK 12'h024
`define OFF_SAMPLE 12'h028

// control register fields
`define CTRL_SIM_BIT 0
`define CTRL_EMODE_LO 1
`define CTRL_EMODE_HI 2
`define CTRL_WSTAT_BIT 3
`define CTRL_LFD_BIT 4
`define CTRL_SUB_WSTAT_BIT 5
`define CTRL_SUB_LF_BIT 6
`define CTRL_SUB_INV_BIT 7
`define CTRL_SIM_WSTAT_BIT 8
`define CTRL_SIM_LF_BIT 9
`define CTRL_SIM_INV_BIT 10
`define CTRL_RESET 32'h00000000

// error modes
`define EMODE_CURRENT 2'h0
`define EMODE_SUBST 2'h1
`define EMODE_LAST 2'h2

// scaling and limit defaults
`define START_DEFAULT 16'h2710
`define END_DEFAULT 16'hC350
`define MIN_DEFAULT 16'h0000
`define MAX_DEFAULT 16'hFFFF

// loop current thresholds in adc codes, 12-bit full scale is 25 mA
`define SHORT_DEFAULT 12'hD71
`define BREAK_DEFAULT 12'h0A4
`define LIVE_ZERO_CODE 12'h24D
`define CODE_4MA 12'h28F
`define CODE_20MA 12'hCCC

// percent values in 0.01 % steps, limits signed 16 bit, full scale 17 bit
`define PCT_MIN 16'hF63C
`define PCT_MAX 16'h30D4
`define PCT_FULL 17'h02710

// timing
`define CLK_HZ 40000000
`define PERIOD_NS 6500000
// 6.5 ms word period and 100 Hz filter step, counted in 25 ns clocks
`define PERIOD_CYCLES 23'h3F7A0
`define TICK_CYCLES 26'h61A80
`define SEC_CYCLES 40000000

// interrupt bits
`define IRQ_SHORT 0
`define IRQ_BREAK 1
`define IRQ_UPDATE 2

`endif

// ===== hdl/ramp_filter.v
`timescale 1ns/100ps
`default_nettype none

// linear slew limiter on the 12-bit loop code
module ramp_filter (
    input wire pclk,
    input wire presetn,
    input wire [11:0] raw,
    input wire [7:0] rate_pct,
    input wire step_tick,
    output reg [11:0] filt
);
    // one step of codes per tick: 4-20 mA span = 2621 codes, pct of it per second
    wire [19:0] span_mul;
    wire [19:0] step_full;
    wire [11:0] step;
    assign span_mul = {8'h00, 12'hA3D} * {12'h000, rate_pct};
    // span * pct / 100 per second, spread over 100 ticks; never below one code
    assign step_full = span_mul / 20'h02710;
    assign step = (step_full == 20'h00000) ? 12'h001 : step_full[11:0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt <= 12'h000;
        end else if (rate_pct == 8'h00) begin
            filt <= raw; // R11
        end else if (step_tick) begin
            if (raw > filt) begin
                filt <= (raw - filt > step) ? filt + step : raw; // R11
            end else begin
                filt <= (filt - raw > step) ? filt - step : raw;
            end
        end
    end
endmodule
`default_nettype wire

// ===== hdl/pct_scale.v
`timescale 1ns/100ps
`default_nettype none

// maps a fraction of range (0..1 as 0..10000) onto start..end codes
module pct_scale (
    input wire signed [17:0] frac,
    input wire [15:0] start_code,
    input wire [15:0] end_code,
    output reg [15:0] scaled
);
    reg signed [17:0] span;
    reg signed [37:0] prod;
    reg signed [37:0] res;
    // signed math so below-zero and over-range percents extrapolate
    always @* begin
        span = $signed({2'b00, end_code}) - $signed({2'b00, start_code});
        prod = span * frac;
        res = $signed({22'h000000, start_code}) + prod / 38'sd10000;
        if (res < 38'sd0) begin
            scaled = 16'h0000;
        end else if (res > 38'sd65535) begin
            scaled = 16'hFFFF;
        end else begin
            scaled = res[15:0]; // R7
        end
    end
endmodule
`default_nettype wire

// ===== hdl/analog_input_value_processing.v
// Overview of operation
// R1: normal forwards field value, simulation forwards sim
// R2: current-value mode forwards live value despite fault
// R3: substitute mode outputs substitute value on fault
// R4: last-valid mode holds value before fault
// R5: status option embeds status in word
// R6: non-default scaling suppresses status bits
// R7: 0% to start code, 100% end code
// R8: line fault triggers diagnosis and error strategy
// R9: short circuit above short threshold
// R10: lead breakage below breakage threshold
// R11: ramp filter limits change; zero disables
// R12: clamp output between min and max
// R13: substitute percent -25..125, scaled
// R14: simulation percent -25..125, output in simulation
// R15: substitute status may attach fault, invalid flags
// R16: simulation invalid flag triggers substitute strategy
// R17: bit0 live zero, bit1 fault, 4+ value
// R18: process word delivered every 6.5 ms
// R19: filter, scale, select, clamp, insert status
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "aivp_defs.vh"

// the two time bases are parameters so a bench can shorten them
module analog_input_value_processing #(
    parameter [22:0] PERIOD_CYC = `PERIOD_CYCLES,
    parameter [25:0] TICK_CYC = `TICK_CYCLES
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [11:0] adc_code,
    input wire adc_valid,
    output reg [15:0] proc_word,
    output reg proc_strobe,
    output reg diag_fault,
    output reg irq
);
    // word period and filter step interval in clocks
    localparam [22:0] PERIOD = PERIOD_CYC;
    localparam [25:0] TICK_DIV = TICK_CYC;

    // configuration registers
    reg [31:0] ctrl_reg;
    reg [15:0] start_reg;
    reg [15:0] end_reg;
    reg [15:0] min_reg;
    reg [15:0] max_reg;
    reg [11:0] short_reg;
    reg [11:0] break_reg;
    reg [15:0] subst_reg;
    reg [15:0] simul_reg;
    reg [7:0] filter_reg;
    // event, sample and held-value state
    reg [2:0] irq_stat_reg;
    reg [2:0] irq_mask_reg;
    reg [11:0] sample_reg;
    reg [15:0] last_valid_reg;
    // time base counters
    reg [22:0] period_cnt_reg;
    reg [25:0] tick_cnt_reg;
    reg short_prev_reg;
    reg break_prev_reg;
    reg [15:0] word_next;

    // control field decode
    wire sim_mode = ctrl_reg[`CTRL_SIM_BIT];
    wire [1:0] emode = ctrl_reg[`CTRL_EMODE_HI:`CTRL_EMODE_LO];
    wire with_status = ctrl_reg[`CTRL_WSTAT_BIT];
    wire lfd_en = ctrl_reg[`CTRL_LFD_BIT];

    // bus strobes and time base ticks
    wire wr_access = psel & penable & pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;
    wire period_tick = (period_cnt_reg == PERIOD - 23'd1);
    wire step_tick = (tick_cnt_reg == TICK_DIV - 26'd1);

    // conversion results are latched; the word period runs independent of them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_reg <= 12'h000;
        end else if (adc_valid) begin
            sample_reg <= adc_code;
        end
    end

    // damping filter stepped at 100 Hz
    wire [11:0] filt_code;
    ramp_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .raw(sample_reg),
        .rate_pct(filter_reg),
        .step_tick(step_tick),
        .filt(filt_code)
    );

    // line fault decisions on the unfiltered code so faults show at once
    wire is_short = sample_reg > short_reg; // R9
    wire is_break = sample_reg < break_reg; // R10
    wire live_zero = sample_reg <= `LIVE_ZERO_CODE;
    wire line_fault = lfd_en & (is_short | is_break); // R8

    // field code to fraction of range in 0.01 % units
    wire signed [31:0] field_num = $signed({20'h00000, filt_code})
        - $signed({20'h00000, `CODE_4MA});
    wire signed [31:0] field_prod = field_num * 32'sd10000;
    wire signed [31:0] field_frac32 = field_prod / 32'sd2621;
    wire signed [17:0] field_frac = field_frac32[17:0];

    // clamp a percent setting to -25..125 %
    function signed [17:0] pct_lim;
        input [15:0] p;
        begin
            if ($signed(p) < $signed(`PCT_MIN)) begin
                pct_lim = {{2{1'b1}}, `PCT_MIN};
            end else if ($signed(p) > $signed(`PCT_MAX)) begin
                pct_lim = {2'b00, `PCT_MAX};
            end else begin
                pct_lim = {{2{p[15]}}, p};
            end
        end
    endfunction

    wire signed [17:0] live_frac = sim_mode ? pct_lim(simul_reg) : field_frac; // R1 R14
    wire [15:0] live_scaled;
    wire [15:0] subst_scaled;
    pct_scale u_live (
        .frac(live_frac),
        .start_code(start_reg),
        .end_code(end_reg),
        .scaled(live_scaled)
    );
    pct_scale u_subst (
        .frac(pct_lim(subst_reg)), // R13
        .start_code(start_reg),
        .end_code(end_reg),
        .scaled(subst_scaled)
    );

    // simulated invalid data counts as a fault for the error strategy
    wire sim_invalid = sim_mode & ctrl_reg[`CTRL_SIM_WSTAT_BIT] & ctrl_reg[`CTRL_SIM_INV_BIT];
    wire fault = line_fault | sim_invalid; // R16
    wire default_scale = (start_reg == `START_DEFAULT) && (end_reg == `END_DEFAULT);
    wire status_ok = with_status & default_scale; // R5 R6

    // select, clamp, then status insertion
    reg [15:0] sel_val;
    reg [1:0] stat_bits;
    reg use_subst;
    always @* begin
        use_subst = 1'b0;
        sel_val = live_scaled; // R2
        case (emode)
            `EMODE_SUBST: begin
                if (fault) begin
                    sel_val = subst_scaled; // R3
                    use_subst = 1'b1;
                end
            end
            `EMODE_LAST: begin
                if (fault) begin
                    sel_val = last_valid_reg; // R4
                end
            end
            default: begin
                sel_val = live_scaled;
            end
        endcase
        if (sel_val < min_reg) begin
            sel_val = min_reg; // R12
        end else if (sel_val > max_reg) begin
            sel_val = max_reg; // R12
        end
    end

    // status bits and word assembly; bits 3:0 of the value are given up for them
    always @* begin
        stat_bits = {line_fault, live_zero & ~sim_mode};
        if (use_subst && ctrl_reg[`CTRL_SUB_WSTAT_BIT]) begin
            stat_bits = {ctrl_reg[`CTRL_SUB_LF_BIT] & line_fault,
                         ctrl_reg[`CTRL_SUB_INV_BIT]}; // R15
        end else if (sim_mode && ctrl_reg[`CTRL_SIM_WSTAT_BIT]) begin
            stat_bits = {ctrl_reg[`CTRL_SIM_LF_BIT] & line_fault,
                         ctrl_reg[`CTRL_SIM_INV_BIT]}; // R16
        end
        if (status_ok) begin
            word_next = {sel_val[15:4], 2'b00, stat_bits}; // R17 R19
        end else begin
            word_next = sel_val; // R6
        end
    end

    // word period counter, free running so delivery ignores conversion timing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_cnt_reg <= 23'd0;
        end else begin
            period_cnt_reg <= period_tick ? 23'd0 : period_cnt_reg + 23'd1; // R18
        end
    end

    // filter step counter; with a nonzero rate the ramp only moves on its wrap
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= 26'd0;
        end else begin
            tick_cnt_reg <= step_tick ? 26'd0 : tick_cnt_reg + 26'd1; // R11
        end
    end

    // process word, last valid value and diagnosis
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            proc_word <= 16'h0000;
            proc_strobe <= 1'b0;
            last_valid_reg <= 16'h0000;
            diag_fault <= 1'b0;
        end else begin
            proc_strobe <= period_tick;
            diag_fault <= line_fault; // R8
            if (period_tick) begin
                proc_word <= word_next; // R18
            end
            if (!fault) begin
                last_valid_reg <= live_scaled; // R4
            end
        end
    end

    // rising edges of each fault kind raise an event only once per fault
    wire short_rise = line_fault & is_short & ~short_prev_reg;
    wire break_rise = line_fault & is_break & ~break_prev_reg;
    wire [2:0] irq_set;
    wire [2:0] irq_clr;
    assign irq_set[`IRQ_SHORT] = short_rise; // R9
    assign irq_set[`IRQ_BREAK] = break_rise; // R10
    assign irq_set[`IRQ_UPDATE] = period_tick;
    assign irq_clr = (wr_access && (paddr == `OFF_IRQ_STAT)) ? pwdata[2:0] : 3'h0;

    // sticky event bits, write one to clear; a set beats a same-cycle clear
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_irq
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    irq_stat_reg[gi] <= 1'b0;
                end else if (irq_set[gi]) begin
                    irq_stat_reg[gi] <= 1'b1;
                end else if (irq_clr[gi]) begin
                    irq_stat_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // apb register writes; unmapped and read-only offsets are ignored
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `CTRL_RESET;
            start_reg <= `START_DEFAULT;
            end_reg <= `END_DEFAULT;
            min_reg <= `MIN_DEFAULT;
            max_reg <= `MAX_DEFAULT;
            short_reg <= `SHORT_DEFAULT;
            break_reg <= `BREAK_DEFAULT;
            subst_reg <= 16'h0000;
            simul_reg <= 16'h0000;
            filter_reg <= 8'h00;
            irq_mask_reg <= 3'h0;
            short_prev_reg <= 1'b0;
            break_prev_reg <= 1'b0;
            irq <= 1'b0;
        end else begin
            short_prev_reg <= line_fault & is_short;
            break_prev_reg <= line_fault & is_break;
            if (wr_access) begin
                case (paddr)
                    `OFF_CTRL: ctrl_reg <= {21'h000000, pwdata[10:0]};
                    `OFF_SCALE: begin
                        start_reg <= pwdata[15:0]; // R7
                        end_reg <= pwdata[31:16];
                    end
                    `OFF_LIMITS: begin
                        min_reg <= pwdata[15:0];
                        max_reg <= pwdata[31:16];
                    end
                    `OFF_THRESH: begin
                        break_reg <= pwdata[11:0];
                        short_reg <= pwdata[27:16];
                    end
                    `OFF_SUBST: subst_reg <= pwdata[15:0];
                    `OFF_SIMUL: simul_reg <= pwdata[15:0];
                    `OFF_FILTER: filter_reg <= pwdata[7:0];
                    `OFF_IRQ_MASK: irq_mask_reg <= pwdata[2:0];
                    default: begin
                    end
                endcase
            end
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // apb read path: no wait state, data ready with pready
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel & ~penable) begin
                pslverr <= (paddr > `OFF_SAMPLE) | (paddr[1:0] != 2'b00);
            end
            if (rd_setup) begin
                case (paddr)
                    `OFF_CTRL: prdata <= ctrl_reg;
                    `OFF_SCALE: prdata <= {end_reg, start_reg};
                    `OFF_LIMITS: prdata <= {max_reg, min_reg};
                    `OFF_THRESH: prdata <= {4'h0, short_reg, 4'h0, break_reg};
                    `OFF_SUBST: prdata <= {16'h0000, subst_reg};
                    `OFF_SIMUL: prdata <= {16'h0000, simul_reg};
                    `OFF_FILTER: prdata <= {24'h000000, filter_reg};
                    `OFF_STATUS: prdata <= {12'h000, proc_word, 1'b0, live_zero, fault, line_fault};
                    `OFF_IRQ_STAT: prdata <= {29'h00000000, irq_stat_reg};
                    `OFF_IRQ_MASK: prdata <= {29'h00000000, irq_mask_reg};
                    `OFF_SAMPLE: prdata <= {20'h00000, sample_reg};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    wire unused_ok = &{1'b0, field_frac32[31:18]}; // quotient never needs these bits
endmodule
`default_nettype wire

// ===== verif/aivp_checker_sva.sv
`timescale 1ns/100ps
`default_nettype none
module aivp_checker #(
    parameter int PERIOD = 260000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [11:0] adc_code,
    input wire logic adc_valid,
    input wire logic [15:0] proc_word,
    input wire logic proc_strobe,
    input wire logic diag_fault,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // gap since the last delivery; the first one has no reference
    logic [18:0] gap_cnt;
    logic seen_word;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt <= 19'h00000;
            seen_word <= 1'b0;
        end else begin
            gap_cnt <= proc_strobe ? 19'h00000 : gap_cnt + 19'h00001;
            seen_word <= seen_word | proc_strobe;
        end
    end
    a_word_period: assert property (proc_strobe && seen_word |-> gap_cnt == 19'(PERIOD - 1))
        else $error("delivery period wrong");
    a_strobe_pulse: assert property (proc_strobe |=> !proc_strobe)
        else $error("delivery pulse longer than one cycle");
    a_word_strobe: assert property (!$stable(proc_word) |-> proc_strobe)
        else $error("word changed without pulse");
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_access: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside access");
    a_bad_addr: assert property (psel && !penable && (paddr > 12'h028 || paddr[1:0] != 2'h0)
        |=> pslverr)
        else $error("bad address accepted");
    a_good_addr: assert property (psel && !penable && paddr <= 12'h028 && paddr[1:0] == 2'h0
        |=> !pslverr)
        else $error("good address refused");
    a_rdata_hold: assert property (!$stable(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data moved without read");
    a_irq_masked: assert property (psel && penable && pwrite && paddr == 12'h024
        && pwdata == 32'h0 |-> ##[1:2] !irq)
        else $error("interrupt with all masked");
    c_word: cover property (proc_strobe && seen_word);
    c_error: cover property (pslverr);
    c_irq: cover property ($rose(irq));
endmodule
bind analog_input_value_processing aivp_checker #(.PERIOD(PERIOD_CYC)) chk (
    .pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_code(adc_code),
    .adc_valid(adc_valid), .proc_word(proc_word), .proc_strobe(proc_strobe),
    .diag_fault(diag_fault), .irq(irq));
`default_nettype wire

// ===== verif/com_unit_model.sv
`timescale 1ns/100ps
`default_nettype none
module com_unit_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] proc_word,
    input wire logic proc_strobe,
    output logic [15:0] got_word,
    output logic got_valid
);
    // the unit copies the word on each delivery pulse only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            got_word <= 16'h0000;
            got_valid <= 1'b0;
        end else begin
            got_valid <= proc_strobe;
            if (proc_strobe) got_word <= proc_word;
        end
    end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [11:0] adc_code = 12'h000;
    logic adc_valid = 1'b0;
    wire [31:0] prdata;
    wire [15:0] proc_word;
    wire [15:0] got_word;
    wire pready, pslverr, proc_strobe, diag_fault, irq, got_valid;
    logic [31:0] rd;
    logic err;
    logic [15:0] exp_q[$];
    int fails = 0;
    int total_checks = 0;
    int seed = 67;

    always #12.5 pclk = ~pclk;

    // shortened time bases keep the run to a few tens of thousands of clocks
    analog_input_value_processing #(.PERIOD_CYC(23'h7D0), .TICK_CYC(26'h0C8)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .adc_code(adc_code), .adc_valid(adc_valid),
        .proc_word(proc_word), .proc_strobe(proc_strobe), .diag_fault(diag_fault), .irq(irq));
    com_unit_model far_end (.pclk(pclk), .presetn(presetn), .proc_word(proc_word),
        .proc_strobe(proc_strobe), .got_word(got_word), .got_valid(got_valid));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // one apb transfer; held until ready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            close_out();
        end
    endtask

    task feed(input logic [11:0] c);
        @(posedge pclk);
        adc_code <= c;
        adc_valid <= 1'b1;
        @(posedge pclk);
        adc_valid <= 1'b0;
    endtask

    // waits for the far end to take a word; no word within 5000 clocks ends the run
    task wait_word;
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (got_valid !== 1'b1 && n < 5000);
        if (got_valid !== 1'b1) begin
            fails++;
            close_out();
        end
    endtask

    task word(input logic [15:0] e, input string name);
        exp_q.push_back(e);
        wait_word();
        $display("test %s done", name);
    endtask

    // compares each delivered word with the oldest note, when a note is queued
    always @(posedge pclk) begin
        if (got_valid === 1'b1 && exp_q.size() > 0) begin
            check({16'h0000, got_word}, {16'h0000, exp_q.pop_front()});
        end
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h00000000);
        apb(1'b0, 12'h030, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'hC3502710);
        wait_word();
        feed(12'hCCC);
        word(16'hC350, "full scale");
        apb(1'b1, 12'h014, 32'h000009C4);
        feed(12'h300 + (12'($random(seed)) & 12'h3FF));
        apb(1'b1, 12'h000, 32'h1);
        word(16'h4E20, "simulation");
        apb(1'b1, 12'h024, 32'h1);
        apb(1'b1, 12'h010, 32'h00001388);
        apb(1'b1, 12'h000, 32'h12);
        feed(12'hE00);
        word(16'h7530, "substitute");
        check({31'h0, diag_fault}, 32'h1);
        check({31'h0, irq}, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        check(rd & 32'h1, 32'h1);
        apb(1'b1, 12'h020, 32'h7);
        apb(1'b1, 12'h024, 32'h0);
        check({31'h0, irq}, 32'h0);
        // last valid needs a good word before the break
        feed(12'h28F);
        apb(1'b1, 12'h000, 32'h14);
        word(16'h2710, "last valid before");
        feed(12'h050);
        word(16'h2710, "last valid held");
        check({31'h0, diag_fault}, 32'h1);
        apb(1'b1, 12'h008, 32'h9C400000);
        apb(1'b1, 12'h014, 32'h00002710);
        apb(1'b1, 12'h000, 32'h1);
        word(16'h9C40, "clamp");
        apb(1'b1, 12'h008, 32'hFFFF0000);
        apb(1'b1, 12'h014, 32'h0);
        feed(12'hE00);
        apb(1'b1, 12'h000, 32'h319);
        word(16'h2712, "status");
        apb(1'b1, 12'h004, 32'hC3500010);
        word(16'h0010, "status omitted");
        // simulated invalid data forces the substitute with its invalid flag
        apb(1'b1, 12'h004, 32'hC3502710);
        apb(1'b1, 12'h000, 32'h5AB);
        word(16'h7531, "invalid simulation");
        // a full-range step with 100 %/s damping cannot finish in one period
        apb(1'b1, 12'h000, 32'h0);
        feed(12'h28F);
        wait_word();
        apb(1'b1, 12'h018, 32'h64);
        feed(12'hCCC);
        wait_word();
        check({31'h0, got_word > 16'h2710 && got_word < 16'hC350}, 32'h1);
        $display("test filter done");
        close_out();
    end
endmodule
`default_nettype wire
